// File: irq_flags_defines.vh
// Functional notes
// RULE_01: Flags set regardless of any enable.
// RULE_02: Software clears stale flags before enabling.
// RULE_03: Parallel port transfer sets bit 7.
// RULE_04: Conversion finish sets bit 6.
// RULE_05: Bit 5 mirrors receive buffer full.
// RULE_06: Bit 4 mirrors transmit buffer empty.
// RULE_07: Sync serial completion sets bit 3.
// RULE_08: Bit 2 sets on capture/compare, not PWM.
// RULE_09: Timer two period match sets bit 1.
// RULE_10: Timer one overflow sets bit 0.
// RULE_11: Missing peripherals leave their flags reserved.
// RULE_12: Second enable register holds bit 0 only.
// RULE_13: Second flag register holds capcmp two flag.
// RULE_14: Power-on reset clears bit 1, software sets.
// RULE_15: Brown-out reset clears bit 0, software sets.
// RULE_16: Disabled brown-out detector leaves bit 0 meaningless.
// RULE_17: Unused upper bits read as zero.
// RULE_18: Peripheral group enable gates peripheral interrupts.
// RULE_19: Global enable gates all interrupts.
// RULE_20: Request is gated OR of enabled flags.
`ifndef IRQ_FLAGS_DEFINES_VH
`define IRQ_FLAGS_DEFINES_VH

`define APB_ADDR_W          10
`define APB_DATA_W          32

`define IDX_IRQ_CONTROL     8'h0b
`define IDX_FLAGS_A         8'h0c
`define IDX_FLAGS_B         8'h0d
`define IDX_ENABLES_A       8'h8c
`define IDX_ENABLES_B       8'h8d
`define IDX_RESET_CAUSE     8'h8e

`define BIT_PARALLEL        7
`define BIT_CONVERSION      6
`define BIT_SERIAL_RX       5
`define BIT_SERIAL_TX       4
`define BIT_SYNC_SERIAL     3
`define BIT_CAPCMP_ONE      2
`define BIT_PERIOD_MATCH    1
`define BIT_TIMER_ONE       0
`define BIT_CAPCMP_TWO      0
`define BIT_POWER_ON        1
`define BIT_BROWNOUT        0
`define BIT_GLOBAL_ENABLE   7
`define BIT_GROUP_ENABLE    6

`define CAPCMP_MODE_CAPTURE 2'h0
`define CAPCMP_MODE_COMPARE 2'h1
`define CAPCMP_MODE_PWM     2'h2

`define BYTE_ZERO           8'h00
`define WORD_ZERO           32'h0000_0000
`define FLAGS_A_SW_MASK     8'hcf

`endif

// File: sticky_flag_cell.v
module sticky_flag_cell #(
	parameter IMPLEMENTED = 1
) (
	input  wire i_clock,
	input  wire i_rst,
	input  wire i_set,
	input  wire i_write,
	input  wire i_wdata,
	output wire o_flag
);

	reg flag_q;
	reg flag_d;

	// A hardware set in the same cycle as a software write wins.
	always @* begin
		flag_d = flag_q;
		if (i_write) begin
			flag_d = i_wdata;
		end
		if (i_set) begin
			flag_d = 1'b1;
		end
		if (IMPLEMENTED == 0) begin
			flag_d = 1'b0;
		end
	end

	always @(posedge i_clock) begin
		if (i_rst) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= flag_d;
		end
	end

	assign o_flag = flag_q;

endmodule // sticky_flag_cell

// File: peripheral_irq_flags_reset_status.v
`include "irq_flags_defines.vh"

module peripheral_irq_flags_reset_status #(
	parameter HAS_PARALLEL_PORT = 1,
	parameter HAS_CONVERTER     = 1
) (
	input  wire                   i_clock,
	input  wire                   i_rst,
	input  wire                   i_power_on_reset,
	input  wire                   i_brownout_reset,
	input  wire                   i_brownout_detect_enable,
	input  wire                   i_parallel_port_done,
	input  wire                   i_conversion_done,
	input  wire                   i_serial_rx_full,
	input  wire                   i_serial_tx_empty,
	input  wire                   i_sync_serial_done,
	input  wire [1:0]             i_capcmp_one_mode,
	input  wire                   i_capcmp_one_capture,
	input  wire                   i_capcmp_one_match,
	input  wire [1:0]             i_capcmp_two_mode,
	input  wire                   i_capcmp_two_capture,
	input  wire                   i_capcmp_two_match,
	input  wire                   i_period_match,
	input  wire                   i_timer_one_overflow,
	input  wire                   i_psel,
	input  wire                   i_penable,
	input  wire                   i_pwrite,
	input  wire [`APB_ADDR_W-1:0] i_paddr,
	input  wire [`APB_DATA_W-1:0] i_pwdata,
	output wire [`APB_DATA_W-1:0] o_prdata,
	output wire                   o_pready,
	output wire                   o_pslverr,
	output wire                   o_irq
);

	localparam [`APB_ADDR_W-1:0] ADDR_IRQ_CONTROL =
		{`IDX_IRQ_CONTROL, 2'h0};
	localparam [`APB_ADDR_W-1:0] ADDR_FLAGS_A = {`IDX_FLAGS_A, 2'h0};
	localparam [`APB_ADDR_W-1:0] ADDR_FLAGS_B = {`IDX_FLAGS_B, 2'h0};
	localparam [`APB_ADDR_W-1:0] ADDR_ENABLES_A = {`IDX_ENABLES_A, 2'h0};
	localparam [`APB_ADDR_W-1:0] ADDR_ENABLES_B = {`IDX_ENABLES_B, 2'h0};
	localparam [`APB_ADDR_W-1:0] ADDR_RESET_CAUSE =
		{`IDX_RESET_CAUSE, 2'h0};

	// Bits of the first flag and enable registers that exist here.
	localparam [7:0] PRESENT_MASK = {
		(HAS_PARALLEL_PORT != 0),
		(HAS_CONVERTER != 0),
		6'h3f
	};

	wire       setup_phase;
	wire       access_phase;
	wire       wr_access;
	wire       hit_control;
	wire       hit_flags_a;
	wire       hit_flags_b;
	wire       hit_enables_a;
	wire       hit_enables_b;
	wire       hit_cause;
	wire       hit_any;
	wire       wr_flags_a;
	wire       wr_flags_b;
	wire [7:0] wdata_byte;

	wire       set_parallel;
	wire       set_conversion;
	wire       set_sync_serial;
	wire       set_capcmp_one;
	wire       set_capcmp_two;
	wire       set_period_match;
	wire       set_timer_one;

	wire       parallel_port_flag;
	wire       conversion_done_flag;
	wire       serial_rx_full_flag;
	wire       serial_tx_empty_flag;
	wire       sync_serial_flag;
	wire       capcmp_one_flag;
	wire       period_match_flag;
	wire       timer_one_overflow_flag;
	wire       capcmp_two_flag;
	wire [7:0] flags_a;
	wire [7:0] flags_b;

	reg  [7:0] enables_a_q;
	reg  [7:0] enables_a_d;
	reg        capcmp_two_enable_q;
	reg        capcmp_two_enable_d;
	reg        global_irq_enable_q;
	reg        global_irq_enable_d;
	reg        peripheral_group_enable_q;
	reg        peripheral_group_enable_d;
	reg        power_on_status_q;
	reg        power_on_status_d;
	reg        brownout_status_q;
	reg        brownout_status_d;
	reg  [7:0] read_byte;
	reg  [`APB_DATA_W-1:0] prdata_q;
	reg  [`APB_DATA_W-1:0] prdata_d;
	reg        pslverr_q;
	reg        pslverr_d;
	reg        irq_q;
	reg        irq_d;

	// The slave never stretches a transfer, so the access phase is the
	// single cycle in which a write lands.
	assign setup_phase   = i_psel & ~i_penable;
	assign access_phase  = i_psel & i_penable;
	assign wr_access     = access_phase & i_pwrite;
	assign hit_control   = (i_paddr == ADDR_IRQ_CONTROL);
	assign hit_flags_a   = (i_paddr == ADDR_FLAGS_A);
	assign hit_flags_b   = (i_paddr == ADDR_FLAGS_B);
	assign hit_enables_a = (i_paddr == ADDR_ENABLES_A);
	assign hit_enables_b = (i_paddr == ADDR_ENABLES_B);
	assign hit_cause     = (i_paddr == ADDR_RESET_CAUSE);
	assign hit_any       = hit_control | hit_flags_a | hit_flags_b |
		hit_enables_a | hit_enables_b | hit_cause;
	assign wr_flags_a    = wr_access & hit_flags_a;
	assign wr_flags_b    = wr_access & hit_flags_b;
	assign wdata_byte    = i_pwdata[7:0];

	// Condition pulses feed the flags with no enable in the path.
	assign set_parallel     = i_parallel_port_done; // [RULE_01] [RULE_03]
	assign set_conversion   = i_conversion_done; // [RULE_04]
	assign set_sync_serial  = i_sync_serial_done; // [RULE_07]
	assign set_period_match = i_period_match; // [RULE_09]
	assign set_timer_one    = i_timer_one_overflow; // [RULE_10]

	// In PWM mode neither unit raises its flag.
	assign set_capcmp_one =
		((i_capcmp_one_mode == `CAPCMP_MODE_CAPTURE) &
		i_capcmp_one_capture) |
		((i_capcmp_one_mode == `CAPCMP_MODE_COMPARE) &
		i_capcmp_one_match); // [RULE_08]
	assign set_capcmp_two =
		((i_capcmp_two_mode == `CAPCMP_MODE_CAPTURE) &
		i_capcmp_two_capture) |
		((i_capcmp_two_mode == `CAPCMP_MODE_COMPARE) &
		i_capcmp_two_match); // [RULE_13]

	// A variant without the port keeps the position reserved at zero.
	sticky_flag_cell #(
		.IMPLEMENTED (HAS_PARALLEL_PORT) // [RULE_11]
	) u_parallel_flag (
		.i_clock (i_clock),
		.i_rst   (i_rst),
		.i_set   (set_parallel),
		.i_write (wr_flags_a),
		.i_wdata (wdata_byte[`BIT_PARALLEL]),
		.o_flag  (parallel_port_flag)
	);

	sticky_flag_cell #(
		.IMPLEMENTED (HAS_CONVERTER) // [RULE_11]
	) u_conversion_flag (
		.i_clock (i_clock),
		.i_rst   (i_rst),
		.i_set   (set_conversion),
		.i_write (wr_flags_a),
		.i_wdata (wdata_byte[`BIT_CONVERSION]),
		.o_flag  (conversion_done_flag)
	);

	sticky_flag_cell #(
		.IMPLEMENTED (1)
	) u_sync_serial_flag (
		.i_clock (i_clock),
		.i_rst   (i_rst),
		.i_set   (set_sync_serial),
		.i_write (wr_flags_a),
		.i_wdata (wdata_byte[`BIT_SYNC_SERIAL]),
		.o_flag  (sync_serial_flag)
	);

	sticky_flag_cell #(
		.IMPLEMENTED (1)
	) u_capcmp_one_flag (
		.i_clock (i_clock),
		.i_rst   (i_rst),
		.i_set   (set_capcmp_one),
		.i_write (wr_flags_a),
		.i_wdata (wdata_byte[`BIT_CAPCMP_ONE]),
		.o_flag  (capcmp_one_flag)
	);

	sticky_flag_cell #(
		.IMPLEMENTED (1)
	) u_period_match_flag (
		.i_clock (i_clock),
		.i_rst   (i_rst),
		.i_set   (set_period_match),
		.i_write (wr_flags_a),
		.i_wdata (wdata_byte[`BIT_PERIOD_MATCH]),
		.o_flag  (period_match_flag)
	);

	sticky_flag_cell #(
		.IMPLEMENTED (1)
	) u_timer_one_flag (
		.i_clock (i_clock),
		.i_rst   (i_rst),
		.i_set   (set_timer_one),
		.i_write (wr_flags_a),
		.i_wdata (wdata_byte[`BIT_TIMER_ONE]),
		.o_flag  (timer_one_overflow_flag)
	);

	sticky_flag_cell #(
		.IMPLEMENTED (1)
	) u_capcmp_two_flag (
		.i_clock (i_clock),
		.i_rst   (i_rst),
		.i_set   (set_capcmp_two),
		.i_write (wr_flags_b),
		.i_wdata (wdata_byte[`BIT_CAPCMP_TWO]),
		.o_flag  (capcmp_two_flag)
	); // [RULE_13]

	// The serial flags are live views of the buffer state; writes to
	// these two positions are dropped.
	assign serial_rx_full_flag  = i_serial_rx_full; // [RULE_05]
	assign serial_tx_empty_flag = i_serial_tx_empty; // [RULE_06]

	assign flags_a = {
		parallel_port_flag,
		conversion_done_flag,
		serial_rx_full_flag,
		serial_tx_empty_flag,
		sync_serial_flag,
		capcmp_one_flag,
		period_match_flag,
		timer_one_overflow_flag
	};
	assign flags_b = {7'h00, capcmp_two_flag}; // [RULE_17]

	always @* begin
		enables_a_d               = enables_a_q;
		capcmp_two_enable_d       = capcmp_two_enable_q;
		global_irq_enable_d       = global_irq_enable_q;
		peripheral_group_enable_d = peripheral_group_enable_q;
		if (wr_access & hit_enables_a) begin
			enables_a_d = wdata_byte & PRESENT_MASK; // [RULE_11]
		end
		if (wr_access & hit_enables_b) begin
			capcmp_two_enable_d = wdata_byte[`BIT_CAPCMP_TWO]; // [RULE_12]
		end
		if (wr_access & hit_control) begin
			global_irq_enable_d       = wdata_byte[`BIT_GLOBAL_ENABLE];
			peripheral_group_enable_d = wdata_byte[`BIT_GROUP_ENABLE];
		end
	end

	always @(posedge i_clock) begin
		if (i_rst) begin
			enables_a_q               <= `BYTE_ZERO;
			capcmp_two_enable_q       <= 1'b0; // [RULE_12]
			global_irq_enable_q       <= 1'b0;
			peripheral_group_enable_q <= 1'b0;
		end else begin
			enables_a_q               <= enables_a_d;
			capcmp_two_enable_q       <= capcmp_two_enable_d;
			global_irq_enable_q       <= global_irq_enable_d;
			peripheral_group_enable_q <= peripheral_group_enable_d;
		end
	end

	// The cause bits survive the ordinary reset so that software can
	// tell afterwards which kind of reset hit the device. A power-on pulse, or a
	// brown-out pulse while detection is enabled, beats a software write landing in the same cycle.
	always @* begin
		power_on_status_d = power_on_status_q;
		brownout_status_d = brownout_status_q;
		if (wr_access & hit_cause) begin
			power_on_status_d = wdata_byte[`BIT_POWER_ON]; // [RULE_14]
			brownout_status_d = wdata_byte[`BIT_BROWNOUT]; // [RULE_15]
		end
		if (i_brownout_reset & i_brownout_detect_enable) begin
			brownout_status_d = 1'b0; // [RULE_15] [RULE_16]
		end
		if (i_power_on_reset) begin
			power_on_status_d = 1'b0; // [RULE_14]
			brownout_status_d = 1'b0;
		end
	end

	always @(posedge i_clock) begin
		power_on_status_q <= power_on_status_d;
		brownout_status_q <= brownout_status_d;
	end

	always @* begin
		read_byte = `BYTE_ZERO;
		if (hit_control) begin
			read_byte[`BIT_GLOBAL_ENABLE] = global_irq_enable_q;
			read_byte[`BIT_GROUP_ENABLE]  = peripheral_group_enable_q;
		end
		if (hit_flags_a) begin
			read_byte = flags_a;
		end
		if (hit_flags_b) begin
			read_byte = flags_b;
		end
		if (hit_enables_a) begin
			read_byte = enables_a_q;
		end
		if (hit_enables_b) begin
			read_byte[`BIT_CAPCMP_TWO] = capcmp_two_enable_q; // [RULE_17]
		end
		if (hit_cause) begin
			read_byte[`BIT_POWER_ON] = power_on_status_q; // [RULE_17]
			read_byte[`BIT_BROWNOUT] = brownout_status_q;
		end
	end

	// Read data and the error answer are captured in the setup cycle so
	// that both come from flip-flops during the access cycle.
	always @* begin
		prdata_d  = prdata_q;
		pslverr_d = pslverr_q;
		if (setup_phase) begin
			prdata_d  = {24'h00_0000, read_byte};
			pslverr_d = ~hit_any;
		end
	end

	always @(posedge i_clock) begin
		if (i_rst) begin
			prdata_q  <= `WORD_ZERO;
			pslverr_q <= 1'b0;
		end else begin
			prdata_q  <= prdata_d;
			pslverr_q <= pslverr_d;
		end
	end

	always @* begin
		irq_d = global_irq_enable_q & peripheral_group_enable_q &
			(|(flags_a & enables_a_q) |
			(capcmp_two_flag & capcmp_two_enable_q)); // [RULE_18] [RULE_19] [RULE_20]
	end

	always @(posedge i_clock) begin
		if (i_rst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= irq_d;
		end
	end

	assign o_prdata  = prdata_q;
	assign o_pready  = 1'b1;
	assign o_pslverr = pslverr_q & access_phase;
	assign o_irq     = irq_q;

endmodule // peripheral_irq_flags_reset_status

// File: periph_event_model.sv
module periph_event_model (
	input  wire       i_clock,
	input  wire [8:0] i_fire,
	output reg  [8:0] o_event
);
	timeunit 1ns;
	timeprecision 1ns;

	// Each condition line repeats its request one core clock later, for as many clocks as the request is held.
	initial o_event = 9'h000;
	always @(posedge i_clock) begin
		o_event <= i_fire;
	end
endmodule // periph_event_model

// File: irq_flags_chk.sv
`include "irq_flags_defines.vh"

module irq_flags_chk (
	input wire                   i_clock,
	input wire                   i_rst,
	input wire                   i_power_on_reset,
	input wire                   i_serial_rx_full,
	input wire                   i_serial_tx_empty,
	input wire                   i_period_match,
	input wire                   i_timer_one_overflow,
	input wire                   i_psel,
	input wire                   i_penable,
	input wire                   i_pwrite,
	input wire [`APB_ADDR_W-1:0] i_paddr,
	input wire [`APB_DATA_W-1:0] o_prdata,
	input wire                   o_irq
);
	timeunit 1ns;
	timeprecision 1ns;

	wire rd = i_psel & ~i_penable & ~i_pwrite;

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);

	AST_UPPER_ZERO: assert property (o_prdata[31:8] == 24'h00_0000)
		else $error("upper read data not zero");
	AST_RX_MIRROR: assert property (
		rd && i_paddr == 10'h030 |=> o_prdata[5] == $past(i_serial_rx_full))
		else $error("receive flag does not mirror");
	AST_TX_MIRROR: assert property (
		rd && i_paddr == 10'h030 |=> o_prdata[4] == $past(i_serial_tx_empty))
		else $error("transmit flag does not mirror");
	AST_ENB_UNUSED: assert property (
		rd && i_paddr == 10'h234 |=> o_prdata[7:1] == 7'h00)
		else $error("second enable upper bits set");
	AST_FLB_UNUSED: assert property (
		rd && i_paddr == 10'h034 |=> o_prdata[7:1] == 7'h00)
		else $error("second flag upper bits set");
	AST_T1_SET: assert property (
		i_timer_one_overflow ##1 (rd && i_paddr == 10'h030) |=> o_prdata[0])
		else $error("overflow flag not set");
	AST_PER_SET: assert property (
		i_period_match ##1 (rd && i_paddr == 10'h030) |=> o_prdata[1])
		else $error("period flag not set");
	AST_POR_CLR: assert property (
		$fell(i_power_on_reset) && !i_penable ##1 (rd && i_paddr == 10'h238)
		|=> o_prdata[1:0] == 2'h0)
		else $error("power-on did not clear cause");
	AST_IRQ_RST: assert property ($fell(i_rst) |-> !o_irq [*2])
		else $error("request high after reset");
endmodule // irq_flags_chk

bind peripheral_irq_flags_reset_status irq_flags_chk u_irq_flags_chk (
	.i_clock, .i_rst, .i_power_on_reset, .i_serial_rx_full,
	.i_serial_tx_empty, .i_period_match, .i_timer_one_overflow,
	.i_psel, .i_penable, .i_pwrite, .i_paddr, .o_prdata, .o_irq
);

// File: tb_peripheral_irq_flags_reset_status.sv
module tb_peripheral_irq_flags_reset_status;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clock = 1'h0;
	logic        rst = 1'h1;
	logic        por = 1'h1;
	logic        bor = 1'h0;
	logic        bor_en = 1'h1;
	logic        rx_full = 1'h0;
	logic        tx_empty = 1'h0;
	logic [1:0]  mode1 = 2'h0;
	logic [1:0]  mode2 = 2'h0;
	logic        psel = 1'h0;
	logic        penable = 1'h0;
	logic        pwrite = 1'h0;
	logic [9:0]  paddr = 10'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [8:0]  fire = 9'h000;
	wire  [8:0]  ev;
	wire  [31:0] prdata;
	wire         pready;
	wire         pslverr;
	wire         irq;
	logic [31:0] rdata;
	logic        err;
	int          n_errors = 0;
	int          checked = 0;
	logic [8:0]  ms [11] = '{9'h001, 9'h002, 9'h004, 9'h008, 9'h010,
		9'h020, 9'h040, 9'h00c, 9'h00c, 9'h008, 9'h004};
	logic [1:0]  md [11] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h0, 2'h0, 2'h0,
		2'h2, 2'h3, 2'h0, 2'h1};
	logic [7:0]  ex [11] = '{8'h01, 8'h02, 8'h04, 8'h04, 8'h08, 8'h40,
		8'h80, 8'h00, 8'h00, 8'h00, 8'h00};

	always #20 clock = ~clock;

	periph_event_model u_periph_event_model (
		.i_clock(clock), .i_fire(fire), .o_event(ev));

	peripheral_irq_flags_reset_status u_peripheral_irq_flags_reset_status (
		.i_clock(clock), .i_rst(rst), .i_power_on_reset(por),
		.i_brownout_reset(bor), .i_brownout_detect_enable(bor_en),
		.i_parallel_port_done(ev[6]), .i_conversion_done(ev[5]),
		.i_serial_rx_full(rx_full), .i_serial_tx_empty(tx_empty),
		.i_sync_serial_done(ev[4]), .i_capcmp_one_mode(mode1),
		.i_capcmp_one_capture(ev[2]), .i_capcmp_one_match(ev[3]),
		.i_capcmp_two_mode(mode2), .i_capcmp_two_capture(ev[7]),
		.i_capcmp_two_match(ev[8]), .i_period_match(ev[1]),
		.i_timer_one_overflow(ev[0]), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.o_irq(irq));

	task automatic stop_test();
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [9:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clock);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'h1 && n < 16);
		if (pready !== 1'h1) begin
			n_errors++;
			$display("Error at %0t: pready %h expected %h",
				$time, pready, 1'h1);
			stop_test();
		end
		rdata = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic rdc(input logic [9:0] a, input logic [31:0] e);
		apb(1'h0, a, 32'h0000_0000);
		chk(rdata, e);
	endtask

	// The request is held one cycle so the model emits a one-cycle pulse.
	task automatic pulse(input logic [8:0] m);
		fire <= m;
		@(posedge clock);
		fire <= 9'h000;
	endtask

	task automatic irq_is(input logic e);
		repeat (3) @(posedge clock);
		chk({31'h0000_0000, irq}, {31'h0000_0000, e});
	endtask

	task automatic t_reset();
		rdc(10'h234, 32'h0000_0000);
		rdc(10'h034, 32'h0000_0000);
		rdc(10'h238, 32'h0000_0000);
		rdc(10'h030, 32'h0000_0000);
		$display("test reset done");
	endtask

	task automatic t_flags();
		for (int k = 0; k < 11; k++) begin
			mode1 <= md[k];
			pulse(ms[k]);
			rdc(10'h030, {24'h00_0000, ex[k]});
			apb(1'h1, 10'h030, 32'h0000_0000);
			rdc(10'h030, 32'h0000_0000);
		end
		apb(1'h1, 10'h030, 32'h0000_00ff);
		rdc(10'h030, 32'h0000_00cf);
		// The overflow pulse reaches the flag at the edge that lands the
		// clearing write, and the set must win.
		fork
			apb(1'h1, 10'h030, 32'h0000_0000);
			begin
				@(posedge clock);
				fire <= 9'h001;
				@(posedge clock);
				fire <= 9'h000;
			end
		join
		rdc(10'h030, 32'h0000_0001);
		$display("test flags done");
	endtask

	task automatic t_mirror();
		rx_full <= 1'h1;
		tx_empty <= 1'h1;
		apb(1'h1, 10'h030, 32'h0000_0000);
		rdc(10'h030, 32'h0000_0030);
		rx_full <= 1'h0;
		rdc(10'h030, 32'h0000_0010);
		tx_empty <= 1'h0;
		rdc(10'h030, 32'h0000_0000);
		$display("test mirror done");
	endtask

	task automatic t_flags_b();
		pulse(9'h080);
		rdc(10'h034, 32'h0000_0001);
		apb(1'h1, 10'h034, 32'h0000_00fe);
		rdc(10'h034, 32'h0000_0000);
		mode2 <= 2'h2;
		pulse(9'h180);
		rdc(10'h034, 32'h0000_0000);
		mode2 <= 2'h1;
		pulse(9'h100);
		rdc(10'h034, 32'h0000_0001);
		apb(1'h1, 10'h034, 32'h0000_0000);
		apb(1'h1, 10'h234, 32'h0000_00ff);
		rdc(10'h234, 32'h0000_0001);
		$display("test second flags done");
	endtask

	task automatic t_irq();
		apb(1'h1, 10'h230, 32'h0000_0001);
		pulse(9'h001);
		for (int c = 0; c < 4; c++) begin
			apb(1'h1, 10'h02c, {24'h00_0000, 2'(c), 6'h00});
			irq_is(c == 3);
		end
		apb(1'h1, 10'h230, 32'h0000_0000);
		irq_is(1'h0);
		pulse(9'h100);
		irq_is(1'h1);
		apb(1'h1, 10'h034, 32'h0000_0000);
		irq_is(1'h0);
		apb(1'h1, 10'h02c, 32'h0000_0000);
		$display("test request done");
	endtask

	task automatic t_cause();
		apb(1'h1, 10'h238, 32'h0000_00ff);
		rdc(10'h238, 32'h0000_0003);
		bor <= 1'h1;
		@(posedge clock);
		bor <= 1'h0;
		rdc(10'h238, 32'h0000_0002);
		apb(1'h1, 10'h238, 32'h0000_0003);
		bor_en <= 1'h0;
		bor <= 1'h1;
		@(posedge clock);
		bor <= 1'h0;
		rdc(10'h238, 32'h0000_0003);
		bor_en <= 1'h1;
		por <= 1'h1;
		@(posedge clock);
		por <= 1'h0;
		rdc(10'h238, 32'h0000_0000);
		apb(1'h0, 10'h3fc, 32'h0000_0000);
		chk({rdata[30:0], err}, 32'h0000_0001);
		$display("test cause done");
	endtask

	initial begin
		repeat (12) @(posedge clock);
		rst <= 1'h0;
		por <= 1'h0;
		t_reset();
		t_flags();
		t_mirror();
		t_flags_b();
		t_irq();
		t_cause();
		stop_test();
	end
endmodule // tb_peripheral_irq_flags_reset_status
